// File: rtl/dcwtu_regs.sv
`timescale 1ns/1ps

// Summary of operation
// - Bits 7-4 hold the green pre-discharge code, reset 0110b, 0000b lowest voltage.
// - Bits 11-8 hold the blue pre-discharge code, reset 0110b, up to 1111b highest.
// - Bits 15-12, 19-16, 23-20 hold red, green, blue dummy one-shot levels, reset zero.
// - Bits 27-24, 31-28, 35-32 hold red, green, blue rising one-shot levels, reset zero.
// - Bits 39, 40, 41 select red, green, blue immunity, reset 1 meaning low immunity.
// - Bit 42, reset 0, limits the maximum PWM subperiod to 256 when set.
// - Layout code 000b gives 16x16 pixels and 001b gives 32x32 pixels.
// - Codes 010b, 100b, 101b give 48x48 D1-D2-D3, 48x64 D1-D2-D3 and 48x64 D1-D3-D2.
// - Codes 110b and 111b give 64x64 with scan D1-D2-D3-D4 and D1-D4-D2-D3.
// - Bit 47, reset 0, enables matrix power saving when set.
// - Bits 3-0 hold the red pre-discharge code, reset 0110b.
module dcwtu_regs
    import dcwtu_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pre-discharge codes
    output logic [3:0] red_predischarge_voltage,
    output logic [3:0] green_predischarge_voltage,
    output logic [3:0] blue_predischarge_voltage,
    // One-shot levels
    output logic [3:0] red_dummy_oneshot_level,
    output logic [3:0] green_dummy_oneshot_level,
    output logic [3:0] blue_dummy_oneshot_level,
    output logic [3:0] red_rising_oneshot_level,
    output logic [3:0] green_rising_oneshot_level,
    output logic [3:0] blue_rising_oneshot_level,
    // Group and mode controls
    output logic red_group_noise_select,
    output logic green_group_noise_select,
    output logic blue_group_noise_select,
    output logic subperiod_limit_enable,
    output logic [2:0] module_layout_select,
    output logic matrix_power_saving_enable,
    // Decoded layout and subperiod limit
    output logic [2:0] stacked_devices,
    output logic [1:0] reversed_devices,
    output logic [1:0] scan_order,
    output logic [8:0] max_subperiod
);

    // ----------------------------------------
    // Word storage
    // ----------------------------------------
    logic [47:0] word_reg;
    logic [47:0] word_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    logic access;
    logic setup;
    logic unmapped;
    assign access = psel && penable;
    assign setup = psel && !penable;
    assign unmapped = (paddr != FCW2_LO_OFFSET) && (paddr != FCW2_HI_OFFSET)
                      && (paddr != STATUS_OFFSET);

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access && unmapped;
    assign prdata = prdata_reg;

    always_comb begin
        logic [31:0] merged;
        merged = 32'h0000_0000;
        word_next = word_reg;
        prdata_next = prdata_reg;
        if (access && pwrite) begin
            if (paddr == FCW2_LO_OFFSET) begin
                word_next[31:0] = merge_bytes(word_reg[31:0], pwdata, pstrb);
            end else if (paddr == FCW2_HI_OFFSET) begin
                merged = merge_bytes({16'h0000, word_reg[47:32]}, pwdata, pstrb);
                word_next[47:32] = merged[15:0];
            end
        end else if (setup && !pwrite) begin
            // Loaded in setup so the word stands at the completing access edge
            if (paddr == FCW2_LO_OFFSET) begin
                prdata_next = word_reg[31:0];
            end else if (paddr == FCW2_HI_OFFSET) begin
                prdata_next = {16'h0000, word_reg[47:32]};
            end else if (paddr == STATUS_OFFSET) begin
                prdata_next = {16'h0000, max_subperiod, scan_order, reversed_devices,
                               stacked_devices};
            end else begin
                prdata_next = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_reg <= FCW2_RESET;
            prdata_reg <= 32'h0000_0000;
        end else begin
            word_reg <= word_next;
            prdata_reg <= prdata_next;
        end
    end

    // ----------------------------------------
    // Field outputs
    // ----------------------------------------
    assign red_predischarge_voltage = word_reg[RED_PDC_LSB +: 4];
    assign green_predischarge_voltage = word_reg[GRN_PDC_LSB +: 4];
    assign blue_predischarge_voltage = word_reg[BLU_PDC_LSB +: 4];
    assign red_dummy_oneshot_level = word_reg[RED_DUMMY_LSB +: 4];
    assign green_dummy_oneshot_level = word_reg[GRN_DUMMY_LSB +: 4];
    assign blue_dummy_oneshot_level = word_reg[BLU_DUMMY_LSB +: 4];
    assign red_rising_oneshot_level = word_reg[RED_RISE_LSB +: 4];
    assign green_rising_oneshot_level = word_reg[GRN_RISE_LSB +: 4];
    assign blue_rising_oneshot_level = word_reg[BLU_RISE_LSB +: 4];
    assign red_group_noise_select = word_reg[RED_NOISE_BIT];
    assign green_group_noise_select = word_reg[GRN_NOISE_BIT];
    assign blue_group_noise_select = word_reg[BLU_NOISE_BIT];
    assign subperiod_limit_enable = word_reg[SUBP_LIMIT_BIT];
    assign module_layout_select = word_reg[LAYOUT_LSB +: 3];
    assign matrix_power_saving_enable = word_reg[POWER_SAVE_BIT];

    // Zero means no limit beyond the normal subperiod range
    assign max_subperiod = subperiod_limit_enable ? 9'h100 : 9'h000;

    // ----------------------------------------
    // Layout decode
    // ----------------------------------------
    always_comb begin
        stacked_devices = 3'h1;
        reversed_devices = 2'h0;
        scan_order = SCAN_NATURAL;
        case (dcwtu_layout_t'(module_layout_select))
            LAYOUT_16X16: begin
                stacked_devices = 3'h1;
            end
            LAYOUT_32X32: begin
                stacked_devices = 3'h2;
            end
            LAYOUT_48X48_D123: begin
                stacked_devices = 3'h3;
                reversed_devices = 2'h1;
            end
            LAYOUT_48X48_D132: begin
                stacked_devices = 3'h3;
                reversed_devices = 2'h1;
                scan_order = SCAN_SWAP23;
            end
            LAYOUT_48X64_D123: begin
                stacked_devices = 3'h4;
                reversed_devices = 2'h2;
            end
            LAYOUT_48X64_D132: begin
                stacked_devices = 3'h4;
                reversed_devices = 2'h2;
                scan_order = SCAN_SWAP23;
            end
            LAYOUT_64X64_D1234: begin
                stacked_devices = 3'h4;
                reversed_devices = 2'h2;
            end
            LAYOUT_64X64_D1423: begin
                stacked_devices = 3'h4;
                reversed_devices = 2'h2;
                scan_order = SCAN_D4_SECOND;
            end
            default: begin
                stacked_devices = 3'h1;
            end
        endcase
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_GREEN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == FCW2_LO_OFFSET && pstrb[0])
        |=> green_predischarge_voltage == $past(pwdata[7:4]))
        else $error("green code not written");
    AST_BLUE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == FCW2_LO_OFFSET && pstrb[1])
        |=> blue_predischarge_voltage == $past(pwdata[11:8]))
        else $error("blue code not written");
    AST_RED_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == FCW2_LO_OFFSET && pstrb[0])
        |=> red_predischarge_voltage == $past(pwdata[3:0]))
        else $error("red code not written");
    AST_DUMMY_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == FCW2_LO_OFFSET && pstrb[2])
        |=> {blue_dummy_oneshot_level, green_dummy_oneshot_level} == $past(pwdata[23:16]))
        else $error("dummy levels not written");
    AST_RISE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == FCW2_HI_OFFSET && pstrb[0])
        |=> blue_rising_oneshot_level == $past(pwdata[3:0]))
        else $error("blue rising level not written");
    AST_NOISE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == FCW2_HI_OFFSET && pstrb[1:0] == 2'h3)
        |=> {blue_group_noise_select, green_group_noise_select, red_group_noise_select}
            == $past(pwdata[9:7]))
        else $error("immunity selects not written");
    AST_SUBP_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == FCW2_HI_OFFSET && pstrb[1])
        |=> subperiod_limit_enable == $past(pwdata[10])
            && max_subperiod[8] == $past(pwdata[10]) && max_subperiod[7:0] == 8'h00)
        else $error("subperiod limit mismatch");
    AST_LAYOUT_48: assert property (@(posedge pclk) disable iff (!presetn)
        (module_layout_select == 3'h2 || module_layout_select == 3'h3)
        |-> stacked_devices == 3'h3 && reversed_devices == 2'h1)
        else $error("48x48 layout decode wrong");
    AST_LAYOUT_64: assert property (@(posedge pclk) disable iff (!presetn)
        (module_layout_select == 3'h7) |-> scan_order == SCAN_D4_SECOND)
        else $error("64x64 scan order wrong");
    AST_POWER_SAVE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == FCW2_HI_OFFSET && pstrb[1])
        |=> matrix_power_saving_enable == $past(pwdata[15]))
        else $error("power saving bit not written");
    AST_SMALL_LAYOUT: assert property (@(posedge pclk) disable iff (!presetn)
        (module_layout_select == 3'h1) |-> stacked_devices == 3'h2)
        else $error("32x32 layout decode wrong");

    // ----------------------------------------
    // Further field writes, word hold and word reset
    // ----------------------------------------
    AST_RED_DUMMY: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == FCW2_LO_OFFSET && pstrb[1])
        |=> red_dummy_oneshot_level == $past(pwdata[15:12]))
        else $error("red dummy level not written");
    AST_RED_GREEN_RISE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == FCW2_LO_OFFSET && pstrb[3])
        |=> {green_rising_oneshot_level, red_rising_oneshot_level} == $past(pwdata[31:24]))
        else $error("red or green rising level not written");
    AST_LAYOUT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == FCW2_HI_OFFSET && pstrb[1])
        |=> module_layout_select == $past(pwdata[13:11]))
        else $error("layout code not written");
    AST_WORD_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !(access && pwrite && (paddr == FCW2_LO_OFFSET || paddr == FCW2_HI_OFFSET))
        |=> $stable(word_reg))
        else $error("word changed without a write");
    AST_RESET_WORD: assert property (@(posedge pclk)
        !presetn |=> word_reg == FCW2_RESET)
        else $error("word not at its reset value");

    // ----------------------------------------
    // Further layout decode
    // ----------------------------------------
    AST_LAYOUT_16: assert property (@(posedge pclk) disable iff (!presetn)
        (module_layout_select == 3'h0)
        |-> stacked_devices == 3'h1 && reversed_devices == 2'h0 && scan_order == SCAN_NATURAL)
        else $error("16x16 layout decode wrong");
    AST_LAYOUT_48_D123: assert property (@(posedge pclk) disable iff (!presetn)
        (module_layout_select == 3'h2) |-> scan_order == SCAN_NATURAL)
        else $error("48x48 natural scan wrong");
    AST_LAYOUT_48_D132: assert property (@(posedge pclk) disable iff (!presetn)
        (module_layout_select == 3'h3) |-> scan_order == SCAN_SWAP23)
        else $error("48x48 swapped scan wrong");
    AST_LAYOUT_48X64: assert property (@(posedge pclk) disable iff (!presetn)
        (module_layout_select == 3'h4 || module_layout_select == 3'h5)
        |-> stacked_devices == 3'h4 && reversed_devices == 2'h2)
        else $error("48x64 layout decode wrong");
    AST_LAYOUT_48X64_SCAN: assert property (@(posedge pclk) disable iff (!presetn)
        (module_layout_select == 3'h5) |-> scan_order == SCAN_SWAP23)
        else $error("48x64 swapped scan wrong");
    AST_LAYOUT_64_DEVICES: assert property (@(posedge pclk) disable iff (!presetn)
        (module_layout_select == 3'h6 || module_layout_select == 3'h7)
        |-> stacked_devices == 3'h4 && reversed_devices == 2'h2)
        else $error("64x64 layout decode wrong");
    AST_LAYOUT_64_NATURAL: assert property (@(posedge pclk) disable iff (!presetn)
        (module_layout_select == 3'h6) |-> scan_order == SCAN_NATURAL)
        else $error("64x64 natural scan wrong");

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    AST_READ_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == FCW2_LO_OFFSET)
        |=> prdata == $past(word_reg[31:0]))
        else $error("low word read wrong");
    AST_READ_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == FCW2_HI_OFFSET)
        |=> prdata == {16'h0000, $past(word_reg[47:32])})
        else $error("high word read wrong");
    AST_READ_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == STATUS_OFFSET)
        |=> prdata[2:0] == $past(stacked_devices) && prdata[6:5] == $past(scan_order))
        else $error("status read wrong");

endmodule : dcwtu_regs

// File: rtl/dcwtu_pkg.sv
package dcwtu_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] FCW2_LO_OFFSET = 12'h000;
    localparam logic [11:0] FCW2_HI_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;

    // ----------------------------------------
    // Field positions (48-bit word)
    // ----------------------------------------
    localparam int RED_PDC_LSB = 0;
    localparam int GRN_PDC_LSB = 4;
    localparam int BLU_PDC_LSB = 8;
    localparam int RED_DUMMY_LSB = 12;
    localparam int GRN_DUMMY_LSB = 16;
    localparam int BLU_DUMMY_LSB = 20;
    localparam int RED_RISE_LSB = 24;
    localparam int GRN_RISE_LSB = 28;
    localparam int BLU_RISE_LSB = 32;
    localparam int RSVD_LO_LSB = 36;
    localparam int RED_NOISE_BIT = 39;
    localparam int GRN_NOISE_BIT = 40;
    localparam int BLU_NOISE_BIT = 41;
    localparam int SUBP_LIMIT_BIT = 42;
    localparam int LAYOUT_LSB = 43;
    localparam int RSVD_HI_BIT = 46;
    localparam int POWER_SAVE_BIT = 47;

    // ----------------------------------------
    // Reset value of the whole word
    // ----------------------------------------
    localparam logic [3:0] PDC_RESET = 4'h6;
    localparam logic [47:0] FCW2_RESET = 48'h0380_0000_0666;

    // ----------------------------------------
    // Layout codes
    // ----------------------------------------
    typedef enum logic [2:0] {
        LAYOUT_16X16 = 3'h0,
        LAYOUT_32X32 = 3'h1,
        LAYOUT_48X48_D123 = 3'h2,
        LAYOUT_48X48_D132 = 3'h3,
        LAYOUT_48X64_D123 = 3'h4,
        LAYOUT_48X64_D132 = 3'h5,
        LAYOUT_64X64_D1234 = 3'h6,
        LAYOUT_64X64_D1423 = 3'h7
    } dcwtu_layout_t;

    // Scan order codes: 0 = D1 D2 D3 (D4), 1 = D1 D3 D2, 2 = D1 D4 D2 D3
    localparam logic [1:0] SCAN_NATURAL = 2'h0;
    localparam logic [1:0] SCAN_SWAP23 = 2'h1;
    localparam logic [1:0] SCAN_D4_SECOND = 2'h2;

endpackage : dcwtu_pkg

// File: test/dcwtu_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Host controller writing the word over APB
// ----------------------------------------
module dcwtu_host_model #(
    parameter logic [3:0] PDC_CEILING = 4'hb
) (
    // Clock
    input wire logic pclk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end

    // Margin to the supply is kept by capping the code
    function automatic logic [3:0] pdc_code(input logic [3:0] want);
        return (want > PDC_CEILING) ? PDC_CEILING : want;
    endfunction : pdc_code

    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                        input logic [3:0] strb, output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        // Response taken at the edge that completes the transfer
        err = pslverr;
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : dcwtu_host_model

// File: test/display_config_word_two_upper_tb.sv
`timescale 1ns/1ps

module display_config_word_two_upper_tb import dcwtu_pkg::*; ;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb, rpd, gpd, bpd, rdu, gdu, bdu, rri, gri, bri;
    logic rns, gns, bns, subp, pse, err;
    logic [2:0] lay, stk;
    logic [1:0] rev, scn;
    logic [8:0] maxs;
    logic [47:0] fields;
    int mismatches = 0;
    int cmp_count = 0;

    assign fields = {pse, 1'b0, lay, subp, bns, gns, rns, 3'h0, bri, gri, rri, bdu, gdu, rdu,
                     bpd, gpd, rpd};

    dcwtu_host_model u_dcwtu_host_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    dcwtu_regs u_dcwtu_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .red_predischarge_voltage(rpd),
        .green_predischarge_voltage(gpd), .blue_predischarge_voltage(bpd),
        .red_dummy_oneshot_level(rdu), .green_dummy_oneshot_level(gdu),
        .blue_dummy_oneshot_level(bdu), .red_rising_oneshot_level(rri),
        .green_rising_oneshot_level(gri), .blue_rising_oneshot_level(bri),
        .red_group_noise_select(rns), .green_group_noise_select(gns),
        .blue_group_noise_select(bns), .subperiod_limit_enable(subp),
        .module_layout_select(lay), .matrix_power_saving_enable(pse),
        .stacked_devices(stk), .reversed_devices(rev), .scan_order(scn), .max_subperiod(maxs));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        u_dcwtu_host_model.xfer(wr, a, d, s, rdat, err);
        // Outputs settle after the completing edge
        @(negedge pclk);
    endtask : acc

    // Reset values, also after a reset in mid-run
    task automatic test_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        check("port low", 48'(fields[23:0]), 48'h00_0666);
        check("port high", 48'(fields[47:24]), 48'h03_8000);
        acc(1'b0, 12'h000, 32'h0, 4'h0);
        check("low word", 48'(rdat), 48'h0000_0666);
        acc(1'b0, 12'h004, 32'h0, 4'h0);
        check("high word", 48'(rdat), 48'h0380);
        check("subperiod", 48'(maxs), 48'h0);
        $display("test reset done");
    endtask : test_reset

    task automatic test_fields();
        acc(1'b1, 12'h000, {24'h876543, u_dcwtu_host_model.pdc_code(4'h2), 4'h1}, 4'hf);
        acc(1'b1, 12'h004, 32'h0000_ec59, 4'hf);
        check("port low", 48'(fields[23:0]), 48'h65_4321);
        check("port high", 48'(fields[47:24]), 48'hac_0987);
        check("subperiod", 48'(maxs), 48'h100);
        acc(1'b0, 12'h004, 32'h0, 4'h0);
        check("high word", 48'(rdat), 48'hec59);
        acc(1'b0, 12'h008, 32'h0, 4'h0);
        check("stat", 48'(rdat), 48'h8034);
        $display("test fields done");
    endtask : test_fields

    task automatic test_layouts();
        logic [1:0] rev_tab [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};
        logic [1:0] scn_tab [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2};
        logic [2:0] stk_tab [8] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4};
        for (int c = 0; c < 8; c++) begin
            acc(1'b1, 12'h004, {18'h0, 3'(c), 11'h380}, 4'hf);
            check("layout", 48'(lay), 48'(c));
            check("reversed", 48'(rev), 48'(rev_tab[c]));
            check("scan", 48'(scn), 48'(scn_tab[c]));
            check("stacked", 48'(stk), 48'(stk_tab[c]));
            check("subperiod off", 48'(maxs), 48'h0);
            acc(1'b0, 12'h008, 32'h0, 4'h0);
            check("stat", 48'(rdat), 48'({scn_tab[c], rev_tab[c], stk_tab[c]}));
        end
        $display("test layouts done");
    endtask : test_layouts

    task automatic test_strobe_unmapped();
        acc(1'b1, 12'h000, 32'hffff_ffaa, 4'h1);
        acc(1'b1, 12'h00c, 32'h0, 4'hf);
        check("unmapped write error", 48'(err), 48'h1);
        acc(1'b0, 12'h00c, 32'h0, 4'h0);
        check("unmapped read", 48'({err, rdat}), 48'h1_0000_0000);
        acc(1'b1, 12'h008, 32'hffff_ffff, 4'hf);
        check("status write error", 48'(err), 48'h0);
        acc(1'b0, 12'h000, 32'h0, 4'h0);
        check("low word", 48'(rdat), 48'h8765_43aa);
        $display("test strobe and unmapped done");
    endtask : test_strobe_unmapped

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        complete_run();
    end

    initial begin
        presetn = 1'b0;
        test_reset();
        test_fields();
        test_layouts();
        test_strobe_unmapped();
        test_reset();
        complete_run();
    end
endmodule : display_config_word_two_upper_tb
